// ==== src/parallel_io_ports.sv ====
// parallel i/o port logic: output latches, direction, open drain, thresholds, apb slave
// assumes apb master on core_clk; pins arrive asynchronous; peripheral signals on core_clk
//
// What this block does
// [R1] eleven bidirectional ports (16, 8 and 15 bits wide) plus two 16-bit input-only ports
// [R2] per-bit direction bit on bidirectional ports; input-only ports have none
// [R3] input lines have their driver off, pin floats
// [R4] seven bidirectional ports choose push-pull or open-drain per pin
// [R5] five ports choose ttl or cmos input threshold via a control register
// [R6] every pin sampled into the input latch each state time, any direction
// [R7] write to an input line only loads its output latch
// [R8] read of an input line returns the sampled pin
// [R9] read-modify-write on input line: pin value modified into output latch
// [R10] output line: write loads latch and driver puts it on the pin
// [R11] read of an output line returns the output latch
// [R12] read-modify-write on output line modifies latch, thus the pin
// [R13] single bits of the standard ports can be set or cleared alone
// [R14] extension ports allow only whole-word access, no bit access
// [R15] extension ports usable only with both configuration enable bits set
// [R16] each line serves software i/o or an on-chip peripheral
// [R17] after reset all lines are inputs, floating, push-pull selected
`timescale 1ns/1ps

module parallel_io_ports
  import pio_pkg::*;
#(
  parameter int PORTS = `PIO_PORTS,
  parameter int BIDIR_PORTS = `PIO_BIDIR_PORTS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PIO_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`PIO_PORTS-1:0][`PIO_PW-1:0] pin_in,
  output pad_drive_t pad,
  input wire logic [`PIO_PORTS-1:0][`PIO_PW-1:0] alt_sel,
  input wire logic [`PIO_PORTS-1:0][`PIO_PW-1:0] alt_out,
  input wire logic [`PIO_PORTS-1:0][`PIO_PW-1:0] alt_oe,
  output logic [`PIO_THR_PORTS-1:0] threshold_cmos,
  output logic ext_ports_enabled
);

  // the port map is fixed by the lane masks below
  initial begin
    if (PORTS != `PIO_PORTS || BIDIR_PORTS != `PIO_BIDIR_PORTS) begin
      $error("parallel_io_ports: port counts cannot be changed");
    end
  end

  port_word_t out_latch [PORTS];
  port_word_t direction_select [PORTS];
  port_word_t open_drain_select [PORTS];
  port_word_t sync_stage [PORTS];
  port_word_t in_latch [PORTS];
  port_word_t port_val [PORTS];
  logic [`PIO_THR_PORTS-1:0] input_threshold_control;
  port_word_t system_configuration;
  port_word_t extension_peripheral_config;
  logic ext_en;
  reg_sel_t sel;
  logic acc_ok;
  logic wr_take;
  port_word_t wdata;

  // usable lane mask of a port
  function automatic port_word_t width_mask(input logic [3:0] p);
    case (p) inside
      [`PIO_IDX_P0L:`PIO_IDX_P8]: width_mask = `PIO_MASK_8; // R1
      `PIO_IDX_P3: width_mask = `PIO_MASK_15;
      default: width_mask = `PIO_MASK_16;
    endcase
  endfunction

  // ports whose drivers can run open drain
  function automatic logic has_od(input logic [3:0] p);
    has_od = (p == `PIO_IDX_P2) || (p == `PIO_IDX_XBIDIR) ||
             (p >= 4'h6 && p <= `PIO_IDX_P3);
  endfunction

  function automatic logic is_ext(input logic [3:0] p);
    is_ext = (p == `PIO_IDX_XBIDIR) || (p == `PIO_IDX_XIN);
  endfunction

  // address to register; holes and illegal combinations map to k_none
  function automatic reg_sel_t decode(input logic [`PIO_AW-1:0] a);
    reg_sel_t s;
    s.port = a[5:2];
    s.kind = k_none;
    if (a[1:0] == 2'b00) begin
      case (a[11:6])
        `PIO_REG_DATA: s.kind = k_data;
        `PIO_REG_DIR: s.kind = k_dir;
        `PIO_REG_OD: s.kind = k_od;
        `PIO_REG_SET: s.kind = k_set;
        `PIO_REG_CLR: s.kind = k_clr;
        `PIO_REG_MISC: begin
          if (a == `PIO_ADDR_THR) s.kind = k_thr;
          else if (a == `PIO_ADDR_SYS) s.kind = k_sys;
          else if (a == `PIO_ADDR_XPER) s.kind = k_xper;
        end
        default: s.kind = k_none;
      endcase
    end
    if (s.kind inside {k_data, k_dir, k_od, k_set, k_clr} && s.port >= 4'(PORTS)) s.kind = k_none;
    if (s.kind == k_dir && s.port >= 4'(BIDIR_PORTS)) s.kind = k_none; // R2
    if (s.kind == k_od && !has_od(s.port)) s.kind = k_none; // R4
    if ((s.kind == k_set || s.kind == k_clr) && is_ext(s.port)) s.kind = k_none; // R14
    decode = s;
  endfunction

  assign ext_en = system_configuration[`PIO_SYS_EXT_BIT] &
                  extension_peripheral_config[`PIO_XPER_EXT_BIT]; // R15
  assign ext_ports_enabled = ext_en;
  assign threshold_cmos = input_threshold_control; // R5

  // extension port registers answer with an error until both enables are set
  assign sel = decode(paddr);
  assign acc_ok = (sel.kind != k_none) &&
                  !(sel.kind inside {k_data, k_dir, k_od} && is_ext(sel.port) && !ext_en); // R15
  assign wr_take = psel & penable & pwrite & acc_ok;
  assign wdata = pwdata[`PIO_PW-1:0];

  genvar g;
  generate
    for (g = 0; g < `PIO_PORTS; g++) begin : g_port
      localparam logic [3:0] GP = 4'(g);
      port_word_t gpio_oe;

      // two stages so the latch never sees a metastable pin; one sample per state time
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          sync_stage[g] <= `PIO_RST_WORD;
          in_latch[g] <= `PIO_RST_WORD;
        end else begin
          sync_stage[g] <= pin_in[g];
          in_latch[g] <= sync_stage[g]; // R6
        end
      end

      // output lines read the latch, input lines the pin
      assign port_val[g] = width_mask(GP) &
                           ((direction_select[g] & out_latch[g]) | // R11
                            (~direction_select[g] & in_latch[g])); // R8

      // open drain only pulls low; input lines float; extension port dark until enabled
      assign gpio_oe = direction_select[g] & ~(open_drain_select[g] & out_latch[g]) & // R3 R4 R10
                       {`PIO_PW{!is_ext(GP) || ext_en}}; // R15

      // peripherals take the lines they claim
      assign pad.out[g] = width_mask(GP) & ((alt_sel[g] & alt_out[g]) | (~alt_sel[g] & out_latch[g])); // R16
      // input-only ports never drive, not even for a peripheral
      assign pad.oe[g] = width_mask(GP) & {`PIO_PW{g < BIDIR_PORTS}} &
                         ((alt_sel[g] & alt_oe[g]) | (~alt_sel[g] & gpio_oe)); // R2 R16
    end
  endgenerate

  // output latches: plain write, bit set and bit clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `PIO_PORTS; i++) begin
        out_latch[i] <= `PIO_RST_WORD;
      end
    end else if (wr_take) begin
      case (sel.kind)
        k_data: out_latch[sel.port] <= wdata & width_mask(sel.port); // R7 R10
        // rmw: start from what a read returns, so input bits copy the pin
        k_set: out_latch[sel.port] <= (port_val[sel.port] | wdata) & width_mask(sel.port); // R9 R12 R13
        k_clr: out_latch[sel.port] <= port_val[sel.port] & ~wdata; // R9 R12 R13
        default: ;
      endcase
    end
  end

  // direction: zero means input
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `PIO_PORTS; i++) begin
        direction_select[i] <= `PIO_RST_WORD; // R17
      end
    end else if (wr_take && sel.kind == k_dir) begin
      direction_select[sel.port] <= wdata & width_mask(sel.port); // R2
    end
  end

  // open-drain select: zero means push-pull
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `PIO_PORTS; i++) begin
        open_drain_select[i] <= `PIO_RST_WORD; // R17
      end
    end else if (wr_take && sel.kind == k_od) begin
      open_drain_select[sel.port] <= wdata & width_mask(sel.port); // R4
    end
  end

  // threshold and configuration words
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      input_threshold_control <= `PIO_RST_THR;
      system_configuration <= `PIO_RST_WORD;
      extension_peripheral_config <= `PIO_RST_WORD;
    end else if (wr_take) begin
      case (sel.kind)
        k_thr: input_threshold_control <= pwdata[`PIO_THR_PORTS-1:0]; // R5
        k_sys: system_configuration <= wdata; // R15
        k_xper: extension_peripheral_config <= wdata; // R15
        default: ;
      endcase
    end
  end

  // read data and error captured in the setup cycle, so the slave never waits
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= !acc_ok;
      prdata <= 32'h0000_0000;
      if (acc_ok && !pwrite) begin
        case (sel.kind)
          k_data: prdata <= {16'h0000, port_val[sel.port]}; // R8 R11
          k_dir: prdata <= {16'h0000, direction_select[sel.port]};
          k_od: prdata <= {16'h0000, open_drain_select[sel.port]};
          k_set, k_clr: prdata <= {16'h0000, port_val[sel.port]};
          k_thr: prdata <= {27'h000_0000, input_threshold_control};
          k_sys: prdata <= {16'h0000, system_configuration};
          k_xper: prdata <= {16'h0000, extension_peripheral_config};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

  // zero wait states
  assign pready = 1'b1;

endmodule

// ==== src/pio_defs.svh ====
// constants of the parallel port block: register map, port indices, field positions
// assumes a 12-bit byte address on the register bus and 32-bit data words
`ifndef PIO_DEFS_SVH
`define PIO_DEFS_SVH

`define PIO_PORTS 13
`define PIO_BIDIR_PORTS 11
`define PIO_THR_PORTS 5
`define PIO_PW 16
`define PIO_AW 12

// port indices
`define PIO_IDX_P2 4'h0
`define PIO_IDX_XBIDIR 4'h1
`define PIO_IDX_P0L 4'h2
`define PIO_IDX_P8 4'h9
`define PIO_IDX_P3 4'ha
`define PIO_IDX_P5 4'hb
`define PIO_IDX_XIN 4'hc

// lane masks for the narrower ports
`define PIO_MASK_8 16'h00ff
`define PIO_MASK_15 16'h7fff
`define PIO_MASK_16 16'hffff

// register regions, 64 bytes each, one word per port
`define PIO_REG_DATA 6'h00
`define PIO_REG_DIR 6'h01
`define PIO_REG_OD 6'h02
`define PIO_REG_SET 6'h03
`define PIO_REG_CLR 6'h04
`define PIO_REG_MISC 6'h05
`define PIO_ADDR_THR 12'h140
`define PIO_ADDR_SYS 12'h144
`define PIO_ADDR_XPER 12'h148

// configuration bits that unlock the extension ports
`define PIO_SYS_EXT_BIT 2
`define PIO_XPER_EXT_BIT 3

// reset values
`define PIO_RST_WORD 16'h0000
`define PIO_RST_THR 5'h00

`endif

// ==== src/pio_pkg.sv ====
// types shared by the parallel port block
// assumes pio_defs.svh is on the include path
`include "pio_defs.svh"

package pio_pkg;

  typedef logic [`PIO_PW-1:0] port_word_t;

  // pad drive of every port line, packed per port
  typedef struct packed {
    logic [`PIO_PORTS-1:0][`PIO_PW-1:0] out;
    logic [`PIO_PORTS-1:0][`PIO_PW-1:0] oe;
  } pad_drive_t;

  typedef enum logic [3:0] {
    k_none, k_data, k_dir, k_od, k_set, k_clr, k_thr, k_sys, k_xper
  } reg_kind_t;

  typedef struct packed {
    reg_kind_t kind;
    logic [3:0] port;
  } reg_sel_t;

endpackage

// ==== sim/pio_pins.sv ====
// pin-side model: external circuitry seen by the parallel port pins
// assumes pad drive from the port block and a bench-driven external level
`timescale 1ns/1ps
`include "pio_defs.svh"

module pio_pins
  import pio_pkg::*;
(
  input pad_drive_t pad,
  input wire logic [`PIO_PORTS-1:0][`PIO_PW-1:0] ext_level,
  output logic [`PIO_PORTS-1:0][`PIO_PW-1:0] pin_in
);
  // driven lanes show the pad, released lanes the outside source
  assign pin_in = (pad.oe & pad.out) | (~pad.oe & ext_level);
endmodule

// ==== sim/pio_checker_properties.sv ====
// concurrent checks on the parallel port block ports
// assumes one clock domain, reset asynchronous and active high
`timescale 1ns/1ps
`include "pio_defs.svh"

module pio_checker
  import pio_pkg::*;
#(
  parameter int PORTS = `PIO_PORTS,
  parameter int BIDIR_PORTS = `PIO_BIDIR_PORTS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PIO_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [`PIO_PORTS-1:0][`PIO_PW-1:0] pin_in,
  input pad_drive_t pad,
  input wire logic [`PIO_PORTS-1:0][`PIO_PW-1:0] alt_sel,
  input wire logic [`PIO_PORTS-1:0][`PIO_PW-1:0] alt_out,
  input wire logic [`PIO_PORTS-1:0][`PIO_PW-1:0] alt_oe,
  input wire logic [`PIO_THR_PORTS-1:0] threshold_cmos,
  input wire logic ext_ports_enabled
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // slices as plain nets so the sampled functions see one signal
  wire setup = psel & ~penable;
  wire wr_acc = psel & penable & pwrite;
  wire [15:0] wlow = pwdata[15:0];
  wire [15:0] p5 = pin_in[11];

  chk_reset_floats: assert property ($fell(rst) |-> (pad.oe & ~alt_sel) == '0)
    else $error("driver enabled right after reset");
  chk_alt_takeover: assert property ((((pad.oe[0] ^ alt_oe[0]) | (pad.out[0] ^ alt_out[0])) & alt_sel[0]) == 16'h0000)
    else $error("peripheral takeover not honoured");
  chk_lane_unused: assert property (pad.oe[9][15:8] == 8'h00 && pad.out[9][15:8] == 8'h00 && !pad.oe[10][15])
    else $error("lane outside port width active");
  chk_input_only: assert property (pad.oe[11] == 16'h0000 && pad.oe[12] == 16'h0000)
    else $error("input-only port driven");
  chk_bitop_refused: assert property (setup && paddr == 12'h0c4 |=> pslverr)
    else $error("bit access on extension port accepted");
  chk_ext_locked: assert property (wr_acc && paddr == `PIO_ADDR_SYS && !pwdata[2] |=> !ext_ports_enabled)
    else $error("extension ports enabled without system bit");
  chk_latch_drive: assert property (wr_acc && paddr == 12'h000 && !pslverr
    |=> ((pad.out[0] ^ $past(wlow)) & ~alt_sel[0]) == 16'h0000)
    else $error("output latch not on pad");
  chk_pin_sampled: assert property (($stable(p5))[*4] ##0 (setup && paddr == 12'h02c)
    |=> prdata == {16'h0000, $past(p5)})
    else $error("pin sample not returned");
endmodule

bind parallel_io_ports pio_checker #(.PORTS(PORTS), .BIDIR_PORTS(BIDIR_PORTS)) pio_checker_inst (
  .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .pin_in, .pad, .alt_sel, .alt_out, .alt_oe, .threshold_cmos, .ext_ports_enabled);

// ==== sim/parallel_io_ports_test.sv ====
// self-checking bench for the parallel port block
// assumes the pin model on the pads and the bench as apb master
`timescale 1ns/1ps
`include "pio_defs.svh"

module parallel_io_ports_test;
  import pio_pkg::*;
  typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic e;} row_t;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr, ext_ports_enabled, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [`PIO_PORTS-1:0][`PIO_PW-1:0] pin_in, alt_sel, alt_out, alt_oe, ext_level;
  logic [`PIO_THR_PORTS-1:0] threshold_cmos;
  pad_drive_t pad;
  int errors = 0, checked = 0, cycles = 0;
  // reads carry the expected word in d; error rows skip the data compare
  row_t rows[29] = '{
    '{12'h000, 0, 32'h3c5a, 0}, '{12'h040, 0, 32'h0, 0},
    '{12'h000, 1, 32'hffff1234, 0}, '{12'h000, 0, 32'h3c5a, 0},
    '{12'h040, 1, 32'h00ff, 0}, '{12'h000, 0, 32'h3c34, 0},
    '{12'h0c0, 1, 32'h8001, 0}, '{12'h000, 0, 32'h3c35, 0},
    '{12'h100, 1, 32'h0030, 0}, '{12'h040, 1, 32'hffff, 0},
    '{12'h000, 0, 32'h3c05, 0}, '{12'h080, 1, 32'h000f, 0},
    '{12'h080, 0, 32'h000f, 0}, '{12'h088, 0, 32'h0, 1},
    '{12'h0c4, 0, 32'h0, 1}, '{12'h004, 0, 32'h0, 1},
    '{12'h144, 1, 32'h0, 0}, '{12'h144, 1, 32'h4, 0},
    '{12'h148, 1, 32'h8, 0}, '{12'h004, 0, 32'h3c5a, 0},
    '{12'h1fc, 0, 32'h0, 1}, '{12'h140, 1, 32'h1f, 0},
    '{12'h140, 0, 32'h1f, 0}, '{12'h02c, 0, 32'h3c5a, 0},
    '{12'h06c, 0, 32'h0, 1}, '{12'h064, 1, 32'hffff, 0},
    '{12'h064, 0, 32'h00ff, 0}, '{12'h028, 0, 32'h3c5a, 0},
    '{12'h000, 0, 32'h3c05, 0}};

  parallel_io_ports parallel_io_ports_inst (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pad(pad), .alt_sel(alt_sel), .alt_out(alt_out), .alt_oe(alt_oe),
    .threshold_cmos(threshold_cmos), .ext_ports_enabled(ext_ports_enabled));
  pio_pins pio_pins_inst (.pad(pad), .ext_level(ext_level), .pin_in(pin_in));

  task chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task give_verdict();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end
  // hang guard well above the hundred or so cycles of traffic
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    alt_sel = '0; alt_out = '0; alt_oe = '0; ext_level = {13{16'h3c5a}};
    repeat (8) @(posedge core_clk);
    rst <= 0;
    // pins need one sync stage plus the latch before a read can see them
    repeat (3) @(posedge core_clk);
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      chk({31'h0, e}, {31'h0, rows[i].e});
      if (!rows[i].w && !rows[i].e) chk(r, rows[i].d);
    end
    $display("register table done");
    #1;
    chk({16'h0, pad.out[0]}, 32'h3c05);
    chk({16'h0, pad.oe[0]}, 32'hfffa);
    chk({16'h0, pad.oe[1]}, 32'h0);
    chk({27'h0, threshold_cmos, ext_ports_enabled}, 32'h3f);
    $display("pad drive done");
    @(posedge core_clk);
    alt_sel[0] <= 16'hffff; alt_out[0] <= 16'h0f0f; alt_oe[0] <= 16'h00ff;
    @(posedge core_clk);
    #1;
    chk({pad.out[0], pad.oe[0]}, 32'h0f0f00ff);
    @(posedge core_clk);
    alt_sel[0] <= '0;
    $display("peripheral takeover done");
    @(posedge core_clk);
    rst <= 1;
    repeat (2) @(posedge core_clk);
    rst <= 0;
    apb(12'h040, 0, 0);
    chk(r, 32'h0);
    chk({16'h0, pad.oe[0]}, 32'h0);
    chk({31'h0, pready}, 32'h1);
    $display("second reset done");
    give_verdict();
  end
endmodule
